//--- hw/ssr_pkg.sv
// package: constants for the synthesizer serial programming link
package ssr_pkg;
    localparam int WORD_BITS     = 24;
    localparam int SEL_BITS      = 2;
    localparam int CTRL_BITS     = 16;
    localparam int NSPUR_BITS    = 11;
    localparam int SEL_LSB       = 0;
    // selector codes
    localparam logic [1:0] SEL_FEEDBACK  = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam logic [1:0] SEL_CONTROL   = 2'h2;
    localparam logic [1:0] SEL_NOISE     = 2'h3;
    // feedback divider word fields
    localparam int FB_FAST_BIT   = 23;
    localparam int FB_INT_MSB    = 22;
    localparam int FB_INT_LSB    = 14;
    localparam int FB_FRAC_MSB   = 13;
    localparam int FB_FRAC_LSB   = 2;
    // reference divider word fields
    localparam int RF_LOAD_BIT   = 23;
    localparam int RF_MON_MSB    = 22;
    localparam int RF_MON_LSB    = 20;
    localparam int RF_PRE_BIT    = 18;
    localparam int RF_RCNT_MSB   = 17;
    localparam int RF_RCNT_LSB   = 14;
    localparam int RF_MOD_MSB    = 13;
    localparam int RF_MOD_LSB    = 2;
    // host register map (AXI4-Lite byte offsets)
    localparam logic [3:0] REG_DATA    = 4'h0;
    localparam logic [3:0] REG_CTRL    = 4'h4;
    localparam logic [3:0] REG_STATUS  = 4'h8;
    localparam logic [3:0] REG_DIVIDER = 4'hc;
    localparam logic [7:0] DIV_RESET   = 8'h03;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // host transmit states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LOW   = 3'h1,
        ST_HIGH  = 3'h3,
        ST_LOAD  = 3'h2,
        ST_DONE  = 3'h6
    } ssr_state_type;
endpackage

//--- hw/ssr_link_if.sv
// interface: three-wire serial programming link
`timescale 1ns/1ps
interface ssr_link_if;
    logic serial_clock;
    logic serial_data;
    logic load_strobe;
    modport host   (output serial_clock, output serial_data, output load_strobe);
    modport device (input serial_clock, input serial_data, input load_strobe);
endinterface

//--- hw/ssr_edge_sync.sv
// module: two-stage synchroniser with rising-edge detect
`timescale 1ns/1ps
module ssr_edge_sync
(
    input  wire logic mclk,    // system clock
    input  wire logic reset_n, // synchronous reset, active low
    input  wire logic async_in, // pin from outside the domain
    output logic      level,   // synchronised level
    output logic      rise     // one-cycle rising-edge pulse
);
    logic meta;
    logic prev;
    // two flops then an edge compare on the second
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            meta  <= 1'b0;
            level <= 1'b0;
            prev  <= 1'b0;
        end
        else
        begin
            meta  <= async_in;
            level <= meta;
            prev  <= level;
        end
    end
    assign rise = level & ~prev;
endmodule

//--- hw/ssr_device.sv
// module: synthesizer serial word receiver and latch bank
//
// Notes on behaviour
// - shift one bit per serial clock rise
// - words arrive most significant bit first
// - load strobe rise updates exactly one latch
// - bits one and zero pick the latch
// - 00 feedback, 01 reference, 10 control, 11 noise
// - staged modulus used after next feedback write
// - host rewrites feedback after modulus change
// - feedback: fast-lock, integer, fraction fields
// - hold reference, integer, fraction, modulus counts
// - monitor select in reference bits 22..20
// - reference write captures modulus into staging
// - host keeps integer within 31 to 511
// - host keeps modulus 2..4095, fraction below
`timescale 1ns/1ps
module ssr_device
    import ssr_pkg::*;
(
    input  wire logic   mclk,              // system clock
    input  wire logic   reset_n,           // synchronous reset, active low
    ssr_link_if.device  link,              // serial link from host
    output logic [23:0] feedback_word,     // feedback divider latch
    output logic [23:0] reference_word,    // reference divider latch
    output logic [15:0] control_word,      // control latch
    output logic [10:0] noise_spur_word,   // noise and spur latch
    output logic        fast_lock_bit,     // fast-lock enable
    output logic [8:0]  int_count,         // integer feedback count
    output logic [11:0] frac_count,        // fraction numerator
    output logic [11:0] fraction_modulus,  // modulus in use
    output logic [3:0]  ref_count,         // reference divide count
    output logic [2:0]  monitor_select,    // monitor output source
    output logic        load_control_bit,  // load control flag
    output logic        prescaler_select_bit // prescaler select
);
    logic [23:0] shift_reg;
    logic [11:0] modulus_stage;
    logic        sclk_rise;
    logic        data_level;
    logic        load_rise;
    // synchronise the three pins
    ssr_edge_sync u_clk  (.mclk(mclk), .reset_n(reset_n), .async_in(link.serial_clock),
                          .level(), .rise(sclk_rise));
    ssr_edge_sync u_data (.mclk(mclk), .reset_n(reset_n), .async_in(link.serial_data),
                          .level(data_level), .rise());
    ssr_edge_sync u_load (.mclk(mclk), .reset_n(reset_n), .async_in(link.load_strobe),
                          .level(), .rise(load_rise));
    // latch decode from the selector bits
    wire [1:0] sel       = shift_reg[SEL_LSB +: SEL_BITS];
    wire       wr_fb     = load_rise && (sel == SEL_FEEDBACK);
    wire       wr_ref    = load_rise && (sel == SEL_REFERENCE);
    wire       wr_ctrl   = load_rise && (sel == SEL_CONTROL);
    wire       wr_noise  = load_rise && (sel == SEL_NOISE);
    // shift register, msb first
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
            shift_reg <= 24'h000000;
        else if (sclk_rise)
            shift_reg <= {shift_reg[22:0], data_level};
    end
    // destination latches
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            feedback_word   <= 24'h000000;
            reference_word  <= 24'h000000;
            control_word    <= 16'h0000;
            noise_spur_word <= 11'h000;
        end
        else
        begin
            if (wr_fb)
                feedback_word <= shift_reg;
            if (wr_ref)
                reference_word <= shift_reg;
            if (wr_ctrl)
                control_word <= shift_reg[CTRL_BITS-1:0];
            if (wr_noise)
                noise_spur_word <= shift_reg[NSPUR_BITS-1:0];
        end
    end
    // double-buffered modulus
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            modulus_stage    <= 12'h000;
            fraction_modulus <= 12'h000;
        end
        else
        begin
            if (wr_ref)
                modulus_stage <= shift_reg[RF_MOD_MSB:RF_MOD_LSB];
            if (wr_fb)
                fraction_modulus <= modulus_stage;
        end
    end
    // field decode of held words
    assign fast_lock_bit        = feedback_word[FB_FAST_BIT];
    assign int_count            = feedback_word[FB_INT_MSB:FB_INT_LSB];
    assign frac_count           = feedback_word[FB_FRAC_MSB:FB_FRAC_LSB];
    assign ref_count            = reference_word[RF_RCNT_MSB:RF_RCNT_LSB];
    assign monitor_select       = reference_word[RF_MON_MSB:RF_MON_LSB];
    assign load_control_bit     = reference_word[RF_LOAD_BIT];
    assign prescaler_select_bit = reference_word[RF_PRE_BIT];
endmodule

//--- hw/ssr_host.sv
// module: AXI4-Lite controlled serial word sender
`timescale 1ns/1ps
module ssr_host
    import ssr_pkg::*;
(
    input  wire logic  mclk,          // system clock
    input  wire logic  reset_n,       // synchronous reset, active low
    ssr_link_if.host   link,          // serial link to device
    input  wire logic [3:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write strobes
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [3:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready   // read data ready
);
    logic [23:0]   tx_word;
    logic [7:0]    divider;
    logic [7:0]    tick_cnt;
    logic [4:0]    bit_cnt;
    logic          aw_held;
    logic          w_held;
    logic [3:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          done_flag;
    ssr_state_type state;
    ssr_state_type next_state;
    // write channel accept, either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    wire   aw_now  = aw_held || s_axi_awvalid;
    wire   w_now   = w_held || s_axi_wvalid;
    wire   [3:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
    wire   [31:0] wd = w_held ? w_data : s_axi_wdata;
    wire   [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
    wire   do_write = aw_now && w_now && !s_axi_bvalid;
    wire   busy     = (state != ST_IDLE);
    wire   wr_data  = do_write && (wa == REG_DATA) && !busy;
    wire   wr_ctrl  = do_write && (wa == REG_CTRL) && !busy && wd[0] && ws[0];
    wire   wr_div   = do_write && (wa == REG_DIVIDER) && ws[0];
    wire   wr_ok    = (wa == REG_DATA) || (wa == REG_CTRL) || (wa == REG_DIVIDER);
    wire   tick     = (tick_cnt == divider);
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready && !do_write)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !do_write)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    // registers steering the sender
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            tx_word <= 24'h000000;
            divider <= DIV_RESET;
        end
        else
        begin
            if (wr_data)
                tx_word <= wd[23:0];
            if (wr_div)
                divider <= (wd[7:0] == 8'h00) ? 8'h01 : wd[7:0];
        end
    end
    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                REG_DATA:    s_axi_rdata <= {8'h00, tx_word};
                REG_CTRL:    s_axi_rdata <= 32'h00000000;
                REG_STATUS:  s_axi_rdata <= {30'h0, done_flag, busy};
                REG_DIVIDER: s_axi_rdata <= {24'h000000, divider};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    // sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE: if (wr_ctrl) next_state = ST_LOW;
            ST_LOW:  if (tick) next_state = ST_HIGH;
            ST_HIGH: if (tick) next_state = (bit_cnt == 5'h00) ? ST_LOAD : ST_LOW;
            ST_LOAD: if (tick) next_state = ST_DONE;
            ST_DONE: if (tick) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end
    // serial pins, msb first, strobe after last bit
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state     <= ST_IDLE;
            tick_cnt  <= 8'h00;
            bit_cnt   <= 5'h00;
            done_flag <= 1'b0;
            link.serial_clock <= 1'b0;
            link.serial_data  <= 1'b0;
            link.load_strobe  <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            tick_cnt <= (state == ST_IDLE || tick) ? 8'h01 : tick_cnt + 8'h01;
            if (wr_ctrl)
            begin
                bit_cnt   <= 5'(WORD_BITS - 1);
                done_flag <= 1'b0;
                link.serial_data <= tx_word[WORD_BITS-1];
            end
            if (state == ST_LOW && tick)
                link.serial_clock <= 1'b1;
            if (state == ST_HIGH && tick)
            begin
                link.serial_clock <= 1'b0;
                if (bit_cnt != 5'h00)
                begin
                    bit_cnt <= bit_cnt - 5'h01;
                    link.serial_data <= tx_word[bit_cnt - 5'h01];
                end
                else
                    link.load_strobe <= 1'b1;
            end
            if (state == ST_LOAD && tick)
                link.load_strobe <= 1'b0;
            if (state == ST_DONE && tick)
                done_flag <= 1'b1;
        end
    end
endmodule

//--- tb/ssr_link_monitor.sv
// checker: timing of the serial link between host and device
`timescale 1ns/1ps
module ssr_link_monitor
(
    input wire logic mclk,         // system clock
    input wire logic reset_n,      // synchronous reset, active low
    input wire logic serial_clock, // link clock
    input wire logic serial_data,  // link data
    input wire logic load_strobe   // latch strobe
);
    logic       prev_clk;  // link clock one cycle ago
    logic [4:0] bit_count; // link clock rises since last strobe
    logic       clk_rise;  // link clock rising this cycle
    // rising-edge detect on the link clock
    assign clk_rise = serial_clock & ~prev_clk;
    // count bits of the word in flight
    always_ff @(posedge mclk)
    begin
        prev_clk <= serial_clock;
        if (!reset_n || load_strobe)
            bit_count <= 5'h0;
        else if (clk_rise)
            bit_count <= bit_count + 5'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    strobe_clk_excl_a: assert property (!(serial_clock && load_strobe))
        else $error("strobe and link clock high together");
    data_hold_a: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_data))
        else $error("data moved while link clock high");
    clk_high_min_a: assert property ($rose(serial_clock) |=> serial_clock [*2])
        else $error("link clock high phase too short");
    clk_low_min_a: assert property ($fell(serial_clock) |=> !serial_clock [*2])
        else $error("link clock low phase too short");
    strobe_min_a: assert property ($rose(load_strobe) |=> load_strobe [*2])
        else $error("strobe pulse too short");
    strobe_end_a: assert property ($rose(load_strobe) |-> ##[1:1000] !load_strobe)
        else $error("strobe stuck high");
    clk_end_a: assert property ($rose(serial_clock) |-> ##[1:1000] !serial_clock)
        else $error("link clock stuck high");
    word_len_a: assert property ($rose(load_strobe) |-> bit_count == 5'd24)
        else $error("word length not 24 bits");
endmodule

//--- tb/tb.sv
// testbench: host sender and device receiver over the serial link
`timescale 1ns/1ps
module tb;
    import ssr_pkg::*;
    logic mclk = 0, reset_n = 0;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, v;
    logic [1:0] bresp, rresp;
    logic [23:0] feedback_word, reference_word;
    logic [15:0] control_word;
    logic [10:0] noise_spur_word;
    logic fast_lock_bit, load_control_bit, prescaler_select_bit;
    logic [8:0] int_count;
    logic [11:0] frac_count, fraction_modulus;
    logic [3:0] ref_count;
    logic [2:0] monitor_select;
    int err_count = 0, cmp_count = 0;
    ssr_link_if link ();
    ssr_host u_ssr_host (.mclk(mclk), .reset_n(reset_n), .link(link),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ssr_device u_ssr_device (.mclk(mclk), .reset_n(reset_n), .link(link),
        .feedback_word(feedback_word), .reference_word(reference_word),
        .control_word(control_word), .noise_spur_word(noise_spur_word),
        .fast_lock_bit(fast_lock_bit), .int_count(int_count),
        .frac_count(frac_count), .fraction_modulus(fraction_modulus),
        .ref_count(ref_count), .monitor_select(monitor_select),
        .load_control_bit(load_control_bit),
        .prescaler_select_bit(prescaler_select_bit));
    ssr_link_monitor u_ssr_link_monitor (.mclk(mclk), .reset_n(reset_n),
        .serial_clock(link.serial_clock), .serial_data(link.serial_data),
        .load_strobe(link.load_strobe));
    // 40 MHz system clock
    always #12.5 mclk = ~mclk;
    // compare and count
    task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // bus write, readies looked at on the low phase before the taking edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        logic aw, w;
        aw = 1;
        w = 1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (aw || w)
        begin
            @(negedge mclk);
            if (aw && awready) aw = 0;
            if (w && wready) w = 0;
            @(posedge mclk);
            awvalid <= aw;
            wvalid <= w;
        end
        do @(negedge mclk); while (bvalid !== 1'b1);
        chk("bresp", bresp, er);
        @(posedge mclk);
        bready <= 0;
        // one idle edge so the next call does not re-raise bready in this step
        @(posedge mclk);
    endtask
    // bus read
    task automatic rd(input logic [3:0] a, output logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(negedge mclk); while (arready !== 1'b1);
        @(posedge mclk);
        arvalid <= 0;
        do @(negedge mclk); while (rvalid !== 1'b1);
        d = rdata;
        chk("rresp", rresp, er);
        @(posedge mclk);
        rready <= 0;
        // one idle edge so the next call does not re-raise rready in this step
        @(posedge mclk);
    endtask
    // send one word, try to overwrite it while busy, wait for done
    task automatic send(input logic [23:0] w);
        wr(REG_DATA, {8'h0, w});
        wr(REG_CTRL, 32'h1);
        wr(REG_DATA, {8'h0, ~w});
        rd(REG_STATUS, v);
        chk("busy status", v[23:0], 24'h1);
        do rd(REG_STATUS, v); while (v[1:0] !== 2'b10);
        rd(REG_DATA, v);
        chk("data kept", v[23:0], w);
        repeat (4) @(posedge mclk);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_sim();
    end
    // main sequence
    initial
    begin
        repeat (2) @(posedge mclk);
        reset_n <= 1;
        @(posedge mclk);
        chk("feedback_word", feedback_word, 24'h0);
        chk("fraction_modulus", fraction_modulus, 12'h0);
        rd(REG_DIVIDER, v);
        chk("divider", v[23:0], DIV_RESET);
        wr(REG_DIVIDER, 32'h0);
        rd(REG_DIVIDER, v);
        chk("divider zero", v[23:0], 24'h1);
        wr(REG_CTRL, 32'h0);
        rd(REG_STATUS, v);
        chk("idle status", v[23:0], 24'h0);
        rd(REG_CTRL, v);
        chk("ctrl read", v[23:0], 24'h0);
        wr(REG_STATUS, 32'h1, RESP_SLVERR);
        rd(4'h2, v, RESP_SLVERR);
        chk("unmapped read", v[23:0], 24'h0);
        wr(REG_DIVIDER, 32'h4);
        rd(REG_DIVIDER, v);
        chk("divider", v[23:0], 24'h4);
        $display("test reset and divider done");
        send({1'b1, 9'h1ff, 12'h123, SEL_FEEDBACK});
        chk("fast_lock_bit", fast_lock_bit, 1'b1);
        chk("int_count", int_count, 9'h1ff);
        chk("frac_count", frac_count, 12'h123);
        chk("fraction_modulus", fraction_modulus, 12'h0);
        chk("reference_word", reference_word, 24'h0);
        $display("test feedback word done");
        send({1'b1, 3'h5, 1'b0, 1'b1, 4'ha, 12'hfff, SEL_REFERENCE});
        chk("monitor_select", monitor_select, 3'h5);
        chk("ref_count", ref_count, 4'ha);
        chk("load_control_bit", load_control_bit, 1'b1);
        chk("prescaler_select_bit", prescaler_select_bit, 1'b1);
        chk("fraction_modulus", fraction_modulus, 12'h0);
        chk("int_count", int_count, 9'h1ff);
        send({1'b0, 9'h01f, 12'h000, SEL_FEEDBACK});
        chk("fraction_modulus", fraction_modulus, 12'hfff);
        chk("int_count", int_count, 9'h01f);
        $display("test modulus buffering done");
        send({8'h5a, 14'h2b3c, SEL_CONTROL});
        chk("control_word", control_word, {14'h2b3c, SEL_CONTROL});
        send({13'h0, 9'h1a5, SEL_NOISE});
        chk("noise_spur_word", noise_spur_word, {9'h1a5, SEL_NOISE});
        chk("feedback_word", feedback_word, {1'b0, 9'h01f, 14'h0});
        $display("test control and noise words done");
        end_sim();
    end
endmodule
